// *** include/mtc_pkg.sv ***
// constants shared by the modem tone control bank and its tone generator
// assumes a single 100 MHz system clock and a 32-bit classic wishbone bus

// ========================================
// package
package mtc_pkg;
	// ========================================
	// clock and tone timing
	localparam int CLK_HZ = 100_000_000;
	localparam int TONE_LOW_HZ = 400;
	localparam int TONE_HIGH_HZ = 800;
	localparam int TONE_CNT_W = 17;
	localparam int TONE_LOW_HALF = CLK_HZ / (2 * TONE_LOW_HZ);
	localparam int TONE_HIGH_HALF = CLK_HZ / (2 * TONE_HIGH_HZ);

	// ========================================
	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_CODE = 6'h00;
	localparam logic [5:0] IDX_MODE = 6'h01;
	localparam logic [5:0] IDX_SWITCH = 6'h02;
	localparam logic [5:0] IDX_TX = 6'h03;
	localparam int ADR_W = 8;
	localparam int DATA_W = 32;
	localparam int NIB_W = 4;

	// ========================================
	// field positions inside the mode register
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 2;
	localparam int DRX_SEL_BIT = 3;

	// field positions inside the switch register
	localparam int TFREQ_BIT = 0;
	localparam int TGEN_BIT = 1;
	localparam int RX_SEL_BIT = 2;
	localparam int TERM_BIT = 3;

	// field positions inside the transmit register
	localparam int ATT_BIT = 0;
	localparam int TXEN_BIT = 1;
	localparam int TERM_OUT_BIT = 2;
	localparam int LINE_OUT_BIT = 3;

	// ========================================
	// mode field encodings
	localparam logic [2:0] MODE_MODEM_TX = 3'h0;
	localparam logic [2:0] MODE_MODEM_RX = 3'h1;
	localparam logic [2:0] MODE_TONE1 = 3'h2;
	localparam logic [2:0] MODE_TONE2 = 3'h3;
	localparam logic [2:0] MODE_TONE3 = 3'h4;
	localparam logic [2:0] MODE_LOOPBACK = 3'h5;
	localparam logic [2:0] MODE_TEST = 3'h6;
	localparam logic [2:0] MODE_POWER_DOWN = 3'h7;

	// ========================================
	// reset values
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [3:0] NIB_RESET = 4'h0;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// ========================================
	// bus answer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK = 2'b10
	} mtc_bus_state_t;
endpackage : mtc_pkg

// *** hw/mtc_tone.sv ***
// square wave call progress tone generator, 400 or 800 hz
// assumes controls come from flip-flops on the same clock

`timescale 1ns/1ns

// ========================================
// tone generator
module mtc_tone #(
	parameter int LOW_HALF = mtc_pkg::TONE_LOW_HALF,
	parameter int HIGH_HALF = mtc_pkg::TONE_HIGH_HALF
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic enable,
	input wire logic freq_high,
	output logic tone
);
	logic [mtc_pkg::TONE_CNT_W-1:0] count;
	logic [mtc_pkg::TONE_CNT_W-1:0] half;
	logic last;

	// ========================================
	// half period select and end of half period
	assign half = freq_high ? mtc_pkg::TONE_CNT_W'(HIGH_HALF - 1)
		: mtc_pkg::TONE_CNT_W'(LOW_HALF - 1);
	assign last = (count >= half);

	// ========================================
	// counter, held at zero while disabled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= '0;
		end else if (!enable || last) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	// ========================================
	// output level, low and silent while disabled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tone <= 1'b0;
		end else if (!enable) begin
			tone <= 1'b0;
		end else if (last) begin
			tone <= ~tone;
		end
	end
endmodule : mtc_tone

// *** hw/mtc_bank.sv ***
// control register bank of a modem, dtmf and call progress tone front end
// assumes a classic wishbone master on SYS_CLK and datapath signals
// that already run on SYS_CLK

`timescale 1ns/1ns

// ========================================
// register bank
module mtc_bank #(
	parameter int TONE_LOW_HALF = mtc_pkg::TONE_LOW_HALF,
	parameter int TONE_HIGH_HALF = mtc_pkg::TONE_HIGH_HALF
) (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [mtc_pkg::ADR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [mtc_pkg::DATA_W-1:0] WB_DAT_I,
	output logic [mtc_pkg::DATA_W-1:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic [3:0] DTMF_RX_CODE,
	input wire logic DETECT_IN,
	input wire logic RX_DATA_IN,
	input wire logic CLOCK_IN,
	input wire logic AUX_IN,
	input wire logic CRYSTAL_IN,
	output logic DETECT_INDICATOR,
	output logic RX_DATA,
	output logic CLOCK_OUTPUT,
	output logic AUXILIARY_OUTPUT,
	output logic CRYSTAL_DRIVE,
	output logic BLOCK_RESET,
	output logic ANALOG_OUT_EN,
	output logic [2:0] MODE,
	output logic DTMF_RX_INPUT_SELECT,
	output logic RX_INPUT_SELECT,
	output logic TERMINATION_SWITCH,
	output logic TERMINAL_OUT_SELECT,
	output logic LINE_OUT_SELECT,
	output logic TONE_GEN_ENABLE,
	output logic TONE_FREQ_SELECT,
	output logic TRANSMIT_ENABLE,
	output logic DTMF_ATTENUATE,
	output logic MODEM_TX_ON,
	output logic DTMF_TX_ON,
	output logic [3:0] DTMF_TX_CODE,
	output logic CALL_PROGRESS_TONE
);
	// ========================================
	// decoding used in several places
	function automatic logic dtmf_tx_mode(
		input logic [2:0] m,
		input logic line_sel
	);
		dtmf_tx_mode = (m == mtc_pkg::MODE_TONE2)
			|| (m == mtc_pkg::MODE_TONE3)
			|| ((m == mtc_pkg::MODE_LOOPBACK) && !line_sel);
	endfunction : dtmf_tx_mode

	function automatic logic modem_tx_mode(
		input logic [2:0] m,
		input logic line_sel
	);
		modem_tx_mode = (m == mtc_pkg::MODE_MODEM_TX)
			|| ((m == mtc_pkg::MODE_LOOPBACK) && line_sel);
	endfunction : modem_tx_mode

	// ========================================
	// state
	mtc_pkg::mtc_bus_state_t state;
	mtc_pkg::mtc_bus_state_t next_state;
	logic [2:0] mode;
	logic dtmf_rx_input_select;
	logic rx_input_select;
	logic termination_switch;
	logic terminal_out_select;
	logic line_out_select;
	logic tone_gen_enable;
	logic tone_freq_select;
	logic transmit_enable;
	logic dtmf_attenuate;
	logic [3:0] code_written;
	logic [3:0] dtmf_tx_code;
	logic transmit_enable_prev;
	logic [mtc_pkg::DATA_W-1:0] read_data;
	logic [5:0] index;
	logic take;
	logic write_ok;
	logic power_down;
	logic tone;

	// ========================================
	// bus decode
	assign index = WB_ADR_I[mtc_pkg::ADR_W-1:2];
	assign take = (state == mtc_pkg::ST_IDLE) && WB_CYC_I && WB_STB_I;
	assign write_ok = take && WB_WE_I && WB_SEL_I[0];
	assign power_down = (mode == mtc_pkg::MODE_POWER_DOWN);

	// ========================================
	// bus answer state machine
	always_comb begin
		case (state)
			mtc_pkg::ST_IDLE: begin
				next_state = take ? mtc_pkg::ST_ACK : mtc_pkg::ST_IDLE;
			end
			mtc_pkg::ST_ACK: begin
				next_state = mtc_pkg::ST_IDLE;
			end
			default: begin
				next_state = mtc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= mtc_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign WB_ACK_O = (state == mtc_pkg::ST_ACK);
	assign WB_DAT_O = read_data;

	// ========================================
	// read data, captured when the request is taken
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			read_data <= mtc_pkg::UNMAPPED_READ;
		end else if (take) begin
			read_data <= mtc_pkg::UNMAPPED_READ;
			case (index)
				mtc_pkg::IDX_CODE: begin
					read_data[mtc_pkg::NIB_W-1:0] <= DTMF_RX_CODE;
				end
				mtc_pkg::IDX_MODE: begin
					read_data[mtc_pkg::MODE_MSB:mtc_pkg::MODE_LSB] <= mode;
					read_data[mtc_pkg::DRX_SEL_BIT] <= dtmf_rx_input_select;
				end
				mtc_pkg::IDX_SWITCH: begin
					read_data[mtc_pkg::TFREQ_BIT] <= tone_freq_select;
					read_data[mtc_pkg::TGEN_BIT] <= tone_gen_enable;
					read_data[mtc_pkg::RX_SEL_BIT] <= rx_input_select;
					read_data[mtc_pkg::TERM_BIT] <= termination_switch;
				end
				mtc_pkg::IDX_TX: begin
					read_data[mtc_pkg::ATT_BIT] <= dtmf_attenuate;
					read_data[mtc_pkg::TXEN_BIT] <= transmit_enable;
					read_data[mtc_pkg::TERM_OUT_BIT] <= terminal_out_select;
					read_data[mtc_pkg::LINE_OUT_BIT] <= line_out_select;
				end
				default: begin
					read_data <= mtc_pkg::UNMAPPED_READ;
				end
			endcase
		end
	end

	// ========================================
	// mode register, kept through power-down
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mode <= mtc_pkg::MODE_RESET;
			dtmf_rx_input_select <= 1'b0;
		end else if (write_ok && index == mtc_pkg::IDX_MODE) begin
			mode <= WB_DAT_I[mtc_pkg::MODE_MSB:mtc_pkg::MODE_LSB];
			dtmf_rx_input_select <= WB_DAT_I[mtc_pkg::DRX_SEL_BIT];
		end
	end

	// ========================================
	// switch register, cleared in power-down
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tone_freq_select <= 1'b0;
			tone_gen_enable <= 1'b0;
			rx_input_select <= 1'b0;
			termination_switch <= 1'b0;
		end else if (power_down) begin
			tone_freq_select <= 1'b0;
			tone_gen_enable <= 1'b0;
			rx_input_select <= 1'b0;
			termination_switch <= 1'b0;
		end else if (write_ok && index == mtc_pkg::IDX_SWITCH) begin
			tone_freq_select <= WB_DAT_I[mtc_pkg::TFREQ_BIT];
			tone_gen_enable <= WB_DAT_I[mtc_pkg::TGEN_BIT];
			rx_input_select <= WB_DAT_I[mtc_pkg::RX_SEL_BIT];
			termination_switch <= WB_DAT_I[mtc_pkg::TERM_BIT];
		end
	end

	// ========================================
	// transmit register, cleared in power-down
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dtmf_attenuate <= 1'b0;
			transmit_enable <= 1'b0;
			terminal_out_select <= 1'b0;
			line_out_select <= 1'b0;
		end else if (power_down) begin
			dtmf_attenuate <= 1'b0;
			transmit_enable <= 1'b0;
			terminal_out_select <= 1'b0;
			line_out_select <= 1'b0;
		end else if (write_ok && index == mtc_pkg::IDX_TX) begin
			dtmf_attenuate <= WB_DAT_I[mtc_pkg::ATT_BIT];
			transmit_enable <= WB_DAT_I[mtc_pkg::TXEN_BIT];
			terminal_out_select <= WB_DAT_I[mtc_pkg::TERM_OUT_BIT];
			line_out_select <= WB_DAT_I[mtc_pkg::LINE_OUT_BIT];
		end
	end

	// ========================================
	// written dtmf code, write only
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			code_written <= mtc_pkg::NIB_RESET;
		end else if (power_down) begin
			code_written <= mtc_pkg::NIB_RESET;
		end else if (write_ok && index == mtc_pkg::IDX_CODE) begin
			code_written <= WB_DAT_I[mtc_pkg::NIB_W-1:0];
		end
	end

	// ========================================
	// dtmf code latch on the transmit enable rise
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			transmit_enable_prev <= 1'b0;
		end else begin
			transmit_enable_prev <= transmit_enable;
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			dtmf_tx_code <= mtc_pkg::NIB_RESET;
		end else if (power_down) begin
			dtmf_tx_code <= mtc_pkg::NIB_RESET;
		end else if (transmit_enable && !transmit_enable_prev
			&& dtmf_tx_mode(mode, line_out_select)) begin
			dtmf_tx_code <= code_written;
		end
	end

	// ========================================
	// pin levels, forced in power-down
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			DETECT_INDICATOR <= 1'b1;
			RX_DATA <= 1'b1;
			CLOCK_OUTPUT <= 1'b1;
			AUXILIARY_OUTPUT <= 1'b0;
			CRYSTAL_DRIVE <= 1'b0;
		end else if (power_down) begin
			DETECT_INDICATOR <= 1'b1;
			RX_DATA <= 1'b1;
			CLOCK_OUTPUT <= 1'b1;
			AUXILIARY_OUTPUT <= 1'b0;
			CRYSTAL_DRIVE <= 1'b0;
		end else begin
			DETECT_INDICATOR <= DETECT_IN;
			RX_DATA <= RX_DATA_IN;
			CLOCK_OUTPUT <= CLOCK_IN;
			AUXILIARY_OUTPUT <= AUX_IN;
			CRYSTAL_DRIVE <= CRYSTAL_IN;
		end
	end

	// ========================================
	// block halt and transmitter enables
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			BLOCK_RESET <= 1'b1;
			ANALOG_OUT_EN <= 1'b0;
			MODEM_TX_ON <= 1'b0;
			DTMF_TX_ON <= 1'b0;
		end else begin
			BLOCK_RESET <= power_down;
			ANALOG_OUT_EN <= !power_down;
			MODEM_TX_ON <= transmit_enable
				&& modem_tx_mode(mode, line_out_select);
			DTMF_TX_ON <= transmit_enable
				&& dtmf_tx_mode(mode, line_out_select);
		end
	end

	// ========================================
	// call progress tone
	mtc_tone #(
		.LOW_HALF(TONE_LOW_HALF),
		.HIGH_HALF(TONE_HIGH_HALF)
	) u_tone (
		.clk(SYS_CLK),
		.arst_n(ARST_N),
		.enable(tone_gen_enable && !power_down),
		.freq_high(tone_freq_select),
		.tone(tone)
	);

	assign CALL_PROGRESS_TONE = tone;

	// ========================================
	// switch and select outputs, straight from the bits
	assign MODE = mode;
	assign DTMF_RX_INPUT_SELECT = dtmf_rx_input_select;
	assign RX_INPUT_SELECT = rx_input_select;
	assign TERMINATION_SWITCH = termination_switch;
	assign TERMINAL_OUT_SELECT = terminal_out_select;
	assign LINE_OUT_SELECT = line_out_select;
	assign TONE_GEN_ENABLE = tone_gen_enable;
	assign TONE_FREQ_SELECT = tone_freq_select;
	assign TRANSMIT_ENABLE = transmit_enable;
	assign DTMF_ATTENUATE = dtmf_attenuate;
	assign DTMF_TX_CODE = dtmf_tx_code;
endmodule : mtc_bank

// *** bench/mtc_bank_asserts.sv ***
// port checker for the modem tone control bank
// assumes a bind onto mtc_bank and one clock domain
`timescale 1ns/1ns
// ========
// checker
module mtc_bank_chk (
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic WB_ACK_O,
	input wire logic [31:0] WB_DAT_O,
	input wire logic [2:0] MODE,
	input wire logic DETECT_INDICATOR,
	input wire logic RX_DATA,
	input wire logic CLOCK_OUTPUT,
	input wire logic AUXILIARY_OUTPUT,
	input wire logic CRYSTAL_DRIVE,
	input wire logic BLOCK_RESET,
	input wire logic ANALOG_OUT_EN,
	input wire logic TERMINATION_SWITCH,
	input wire logic RX_INPUT_SELECT,
	input wire logic TONE_GEN_ENABLE,
	input wire logic LINE_OUT_SELECT,
	input wire logic TRANSMIT_ENABLE,
	input wire logic DTMF_TX_ON,
	input wire logic MODEM_TX_ON,
	input wire logic [3:0] DTMF_TX_CODE,
	input wire logic CALL_PROGRESS_TONE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	wire logic pd = MODE == 3'h7;
	wire logic req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire logic wr = req && WB_WE_I;
	wire logic [4:0] sw = {TERMINATION_SWITCH, RX_INPUT_SELECT,
		TONE_GEN_ENABLE, LINE_OUT_SELECT, TRANSMIT_ENABLE};
	wire logic [4:0] pins = {DETECT_INDICATOR, RX_DATA, CLOCK_OUTPUT,
		AUXILIARY_OUTPUT, CRYSTAL_DRIVE};
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held");
	ack_due_a: assert property (req |=> WB_ACK_O)
		else $error("no ack");
	rd_upper_a: assert property (
		WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:4] == 28'h0) else $error("upper");
	pd_pins_a: assert property (pd |=> pins == 5'h1C)
		else $error("pins");
	pd_halt_a: assert property (
		1 |=> BLOCK_RESET == $past(pd) && ANALOG_OUT_EN != $past(pd))
		else $error("halt");
	pd_clear_a: assert property (
		$past(pd) |-> {sw, DTMF_TX_CODE} == 9'h0) else $error("clear");
	bit_hold_a: assert property (
		!$stable(sw) |-> $past(wr) || $past(pd)) else $error("bit moved");
	code_hold_a: assert property (
		!$stable(DTMF_TX_CODE) |-> $past(pd) ||
		$past(TRANSMIT_ENABLE) && !$past(TRANSMIT_ENABLE, 2))
		else $error("code moved");
	dtmf_on_a: assert property (
		TRANSMIT_ENABLE && (MODE == 3'h3 || MODE == 3'h4) |=> DTMF_TX_ON)
		else $error("dtmf off");
	modem_on_a: assert property (
		TRANSMIT_ENABLE && MODE == 3'h0 |=> MODEM_TX_ON && !DTMF_TX_ON)
		else $error("modem off");
	tx_off_a: assert property (
		!TRANSMIT_ENABLE |=> !DTMF_TX_ON && !MODEM_TX_ON) else $error("tx on");
	tone_off_a: assert property (
		!TONE_GEN_ENABLE [*3] |-> !CALL_PROGRESS_TONE) else $error("tone on");
endmodule : mtc_bank_chk

bind mtc_bank mtc_bank_chk u_chk (.*);

// *** bench/mtc_cpu.sv ***
// processor model reaching the bank over classic wishbone
// assumes stb is tied to cyc by the bench
`timescale 1ns/1ns
// ========
// bus master
module mtc_cpu (
	input wire logic clk,
	input wire logic ack,
	input wire logic [31:0] rdat,
	output logic cyc,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] wdat
);
	int gap = 0;
	initial begin
		cyc = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h0;
	end
	// one cycle, held until ack is sampled, then released
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q, output logic ok);
		int n;
		n = 0;
		repeat (gap + 1) @(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		ok = ack === 1'b1;
		// released lines show the inverse, not stale values
		cyc <= 1'b0;
		we <= ~w;
		adr <= ~a;
		sel <= ~s;
		wdat <= ~d;
		@(posedge clk);
	endtask : xfer
endmodule : mtc_cpu

// *** bench/tb_top.sv ***
// self-checking bench for the modem tone control bank
// assumes the processor model and the bound checker
`timescale 1ns/1ns
// ========
// bench
module tb_top;
	localparam int LO = 10;
	localparam int HI = 5;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] rxc = 4'h0;
	logic [4:0] pin = 5'h03;
	logic [3:0] s1, s2, s3, c;
	wire logic cyc, we, ack, blk, aen, mtx, dtx, tone;
	wire logic [7:0] adr;
	wire logic [3:0] sel, txc;
	wire logic [31:0] wd, rdat;
	wire logic [2:0] mode;
	wire logic [8:0] bits;
	wire logic [4:0] po;
	int n_mismatch = 0;
	int total_checks = 0;
	int seed = 75570;
	always #5 clk = ~clk;
	mtc_cpu u_cpu (.clk(clk), .ack(ack), .rdat(rdat), .cyc(cyc), .we(we),
		.adr(adr), .sel(sel), .wdat(wd));
	mtc_bank #(.TONE_LOW_HALF(LO), .TONE_HIGH_HALF(HI)) dut (
		.SYS_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .DTMF_RX_CODE(rxc),
		.DETECT_IN(pin[4]), .RX_DATA_IN(pin[3]), .CLOCK_IN(pin[2]),
		.AUX_IN(pin[1]), .CRYSTAL_IN(pin[0]), .DETECT_INDICATOR(po[4]),
		.RX_DATA(po[3]), .CLOCK_OUTPUT(po[2]), .AUXILIARY_OUTPUT(po[1]),
		.CRYSTAL_DRIVE(po[0]), .BLOCK_RESET(blk), .ANALOG_OUT_EN(aen),
		.MODE(mode), .DTMF_RX_INPUT_SELECT(bits[8]),
		.TERMINATION_SWITCH(bits[7]), .RX_INPUT_SELECT(bits[6]),
		.TONE_GEN_ENABLE(bits[5]), .TONE_FREQ_SELECT(bits[4]),
		.LINE_OUT_SELECT(bits[3]), .TERMINAL_OUT_SELECT(bits[2]),
		.TRANSMIT_ENABLE(bits[1]), .DTMF_ATTENUATE(bits[0]),
		.MODEM_TX_ON(mtx), .DTMF_TX_ON(dtx), .DTMF_TX_CODE(txc),
		.CALL_PROGRESS_TONE(tone));
	// ========
	// helpers
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [5:0] i,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
		logic ok;
		u_cpu.xfer(w, {i, 2'($random(seed))}, s, d, r, ok);
		if (!ok) begin
			n_mismatch++;
			conclude();
		end
	endtask : bus
	task automatic wr(input logic [5:0] i, input logic [3:0] d);
		logic [31:0] r;
		bus(1'b1, i, {28'($random(seed)), d}, 4'hF, r);
	endtask : wr
	task automatic rd(input logic [5:0] i, input logic [3:0] e);
		logic [31:0] r;
		bus(1'b0, i, 32'h0, 4'hF, r);
		chk(r, {28'h0, e});
	endtask : rd
	task automatic half(input int e);
		int n;
		logic v;
		n = 0;
		@(posedge clk);
		v = tone;
		while (tone === v && n < 99) begin
			@(posedge clk);
			n++;
		end
		v = tone;
		n = 0;
		while (tone === v && n < 99) begin
			@(posedge clk);
			n++;
		end
		chk(n, e);
	endtask : half
	// modem and dtmf transmitter enables for a mode and register 3
	function automatic logic [1:0] exp_on(input logic [2:0] m,
		input logic [3:0] t);
		exp_on[1] = t[1] && (m == 3'h0 || (m == 3'h5 && t[3]));
		exp_on[0] = t[1] && (m == 3'h3 || m == 3'h4 || (m == 3'h5 && !t[3]));
	endfunction : exp_on
	// ========
	// scenarios
	initial begin
		logic [31:0] q;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		wr(6'h1, 4'hF);
		#1;
		chk({po, blk, aen}, 7'h72);
		for (int k = 0; k < 28; k++) begin
			s1 = {1'($random(seed)), 3'(k % 7)};
			s2 = 4'($random(seed));
			s3 = 4'($random(seed));
			if (s1[2:0] == 3'h1 || s1[2:0] == 3'h2) s3[1] = 1'b0;
			if (s1[2:0] == 3'h0) s3[3] = 1'b1;
			if (s1[2:0] == 3'h3 || s1[2:0] == 3'h4) s3[3] = 1'b0;
			u_cpu.gap = k % 3;
			wr(6'h3, 4'h0);
			wr(6'h1, s1);
			wr(6'h2, s2);
			wr(6'h3, s3);
			rxc <= 4'($random(seed));
			pin <= 5'($random(seed));
			rd(6'h1, s1);
			rd(6'h2, s2);
			rd(6'h3, s3);
			rd(6'h0, rxc);
			#1;
			chk(bits, {s1[3], s2, s3});
			chk(mode, s1[2:0]);
			chk({po, blk, aen}, {pin, 2'h1});
			chk({mtx, dtx}, exp_on(s1[2:0], s3));
		end
		wr(6'h3, 4'h0);
		bus(1'b1, 6'h3, 32'hF, 4'hE, q);
		rd(6'h3, 4'h0);
		wr(6'h9, 4'hF);
		rd(6'h9, 4'h0);
		for (int j = 3; j < 6; j++) begin
			c = 4'($random(seed));
			wr(6'h1, 4'(j));
			wr(6'h0, c);
			wr(6'h3, 4'h2);
			#1;
			chk(txc, c);
			wr(6'h0, ~c);
			#1;
			chk(txc, c);
			wr(6'h3, 4'h0);
		end
		wr(6'h1, 4'h0);
		wr(6'h2, 4'h2);
		half(LO);
		wr(6'h2, 4'h0);
		wr(6'h2, 4'h3);
		half(HI);
		wr(6'h2, 4'h1);
		repeat (3) @(posedge clk);
		#1;
		chk(tone, 1'b0);
		wr(6'h2, 4'hF);
		wr(6'h3, 4'hD);
		wr(6'h1, 4'h7);
		wr(6'h2, 4'hF);
		rd(6'h2, 4'h0);
		rd(6'h3, 4'h0);
		rd(6'h1, 4'h7);
		#1;
		chk({txc, blk}, 5'h01);
		conclude();
	end
endmodule : tb_top
